// ==== verilog/multi_speed_preset_select.sv ====
`timescale 1ns/1ps
// Summary of operation
// RULE_01: a table of sixteen preset frequencies is held, any of which can be the run frequency; the code never runs entry 0, index zero passes the reference.
// RULE_02: a terminal set to function 02 drives index bit 0, active meaning one.
// RULE_03: terminals set to functions 03 and 04 drive index bits 1 and 2.
// RULE_04: a terminal set to function 05 drives index bit 3, the top bit.
// RULE_05: index zero picks the base entry and indices 1 to 15 pick the next entries in order; the code runs the reference at index zero, not entry 0.
// RULE_06: any select function may sit on any of the six terminals in any order.
// RULE_07: users needing eight or fewer speeds assign select bits from the lowest bit upward.
// RULE_08: with terminal source, no active select keeps the terminal reference, else the preset wins.
// RULE_09: select changes during run change the commanded frequency at once.
// RULE_10: an edited value enters the table only on a store keypress.
// RULE_11: in stop, a store writes the edit into the entry chosen by the index, which is then shown.
// RULE_12: operators watch the output monitor rather than the setting during run.
// RULE_13: presets above 50Hz(60Hz) need the maximum frequency raised first.
// RULE_14: the present output frequency is always shown on the monitor output.
// RULE_15: a select bit on no terminal counts as zero in the index.
module multi_speed_preset_select (
  // clock and reset
  input  wire logic                               i_mclk,
  input  wire logic                               i_rst,
  // input terminals and their function assignment
  input  wire logic [preset_pkg::NUM_TERMINALS-1:0] i_terminal,
  input  wire logic [preset_pkg::FUNC_W-1:0]        i_term_func [preset_pkg::NUM_TERMINALS],
  // configuration
  input  wire logic [1:0]                         i_freq_source,
  input  wire logic [preset_pkg::FREQ_W-1:0]      i_max_freq,
  input  wire logic                               i_run,
  // frequency references
  input  wire logic [preset_pkg::FREQ_W-1:0]      i_terminal_ref,
  input  wire logic [preset_pkg::FREQ_W-1:0]      i_other_ref,
  // keypad edit
  input  wire preset_pkg::store_req_t             i_edit,
  // outputs
  output logic [preset_pkg::FREQ_W-1:0]           o_output_frequency_monitor,
  output logic [preset_pkg::FREQ_W-1:0]           o_output_frequency_setting,
  output logic [preset_pkg::INDEX_W-1:0]          o_preset_index,
  output logic                                    o_preset_active,
  output logic                                    o_store_done,
  output logic                                    o_store_rejected
);

  // ----------------------------------------------------------------
  // terminal synchronisers
  // ----------------------------------------------------------------
  logic [preset_pkg::NUM_TERMINALS-1:0] term_meta_r;
  logic [preset_pkg::NUM_TERMINALS-1:0] term_sync_r;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      term_meta_r <= '0;
      term_sync_r <= '0;
    end else begin
      term_meta_r <= i_terminal;
      term_sync_r <= term_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // index forming
  // ----------------------------------------------------------------
  logic [preset_pkg::INDEX_W-1:0] index_nxt;
  logic [preset_pkg::INDEX_W-1:0] assigned_nxt;

  always_comb begin
    index_nxt    = preset_pkg::INDEX_ZERO;
    assigned_nxt = preset_pkg::INDEX_ZERO;
    // RULE_06 any terminal placement
    for (int t = 0; t < preset_pkg::NUM_TERMINALS; t++) begin
      case (i_term_func[t])
        // RULE_02 bit zero
        preset_pkg::FUNC_SEL_BIT0: begin
          index_nxt[0]    = index_nxt[0] | term_sync_r[t];
          assigned_nxt[0] = 1'b1;
        end
        // RULE_03 bits one two
        preset_pkg::FUNC_SEL_BIT1: begin
          index_nxt[1]    = index_nxt[1] | term_sync_r[t];
          assigned_nxt[1] = 1'b1;
        end
        preset_pkg::FUNC_SEL_BIT2: begin
          index_nxt[2]    = index_nxt[2] | term_sync_r[t];
          assigned_nxt[2] = 1'b1;
        end
        // RULE_04 top bit
        preset_pkg::FUNC_SEL_BIT3: begin
          index_nxt[3]    = index_nxt[3] | term_sync_r[t];
          assigned_nxt[3] = 1'b1;
        end
        // RULE_15 unassigned reads zero
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // preset table
  // ----------------------------------------------------------------
  // RULE_01 sixteen entries
  logic [preset_pkg::FREQ_W-1:0] table_r [preset_pkg::NUM_PRESETS];
  logic                          store_ok;
  logic [preset_pkg::INDEX_W-1:0] store_idx;

  // direct edits name their entry; terminal edits use the live index, stop only
  assign store_idx = i_edit.direct ? i_edit.index : index_nxt;
  // a preset above the maximum is refused rather than clipped
  assign store_ok  = i_edit.store && (i_edit.value <= i_max_freq)
                     && (i_edit.direct || !i_run);

  // RULE_10 commit on store
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < preset_pkg::NUM_PRESETS; k++) begin
        table_r[k] <= preset_pkg::PRESET_RESET;
      end
    end else if (store_ok) begin
      // RULE_11 write selected entry
      table_r[store_idx] <= i_edit.value;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_store_done     <= 1'b0;
      o_store_rejected <= 1'b0;
    end else begin
      o_store_done     <= store_ok;
      o_store_rejected <= i_edit.store && !store_ok;
    end
  end

  // ----------------------------------------------------------------
  // frequency selection
  // ----------------------------------------------------------------
  logic                          any_sel;
  logic [preset_pkg::FREQ_W-1:0] freq_nxt;
  logic [preset_pkg::FREQ_W-1:0] setting_nxt;

  assign any_sel = |index_nxt;

  // RULE_08 override on any select
  always_comb begin
    if (i_freq_source == preset_pkg::SRC_TERMINAL) begin
      // RULE_05 index to entry
      freq_nxt = any_sel ? table_r[index_nxt] : i_terminal_ref;
    end else begin
      freq_nxt = any_sel ? table_r[index_nxt] : i_other_ref;
    end
  end

  // the setting view shows the entry chosen by the index, so after a terminal store it shows that entry
  assign setting_nxt = table_r[index_nxt];

  // RULE_09 immediate update
  // RULE_14 monitor follows output
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_output_frequency_monitor <= preset_pkg::FREQ_ZERO;
      o_output_frequency_setting <= preset_pkg::FREQ_ZERO;
      o_preset_index             <= preset_pkg::INDEX_ZERO;
      o_preset_active            <= 1'b0;
    end else begin
      o_output_frequency_monitor <= i_run ? freq_nxt : preset_pkg::FREQ_ZERO;
      o_output_frequency_setting <= setting_nxt;
      o_preset_index             <= index_nxt;
      o_preset_active            <= any_sel;
    end
  end

endmodule : multi_speed_preset_select

// ==== verilog/preset_pkg.sv ====
package preset_pkg;

  // ----------------------------------------------------------------
  // table and terminal geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PRESETS   = 16;
  localparam int unsigned INDEX_W       = 4;
  localparam int unsigned NUM_TERMINALS = 6;
  localparam int unsigned FREQ_W        = 16;
  localparam int unsigned FUNC_W        = 8;

  // ----------------------------------------------------------------
  // terminal function codes
  // ----------------------------------------------------------------
  localparam logic [FUNC_W-1:0] FUNC_SEL_BIT0 = 8'h02;
  localparam logic [FUNC_W-1:0] FUNC_SEL_BIT1 = 8'h03;
  localparam logic [FUNC_W-1:0] FUNC_SEL_BIT2 = 8'h04;
  localparam logic [FUNC_W-1:0] FUNC_SEL_BIT3 = 8'h05;

  // ----------------------------------------------------------------
  // frequency source codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]        SRC_TERMINAL  = 2'h1;
  localparam logic [FREQ_W-1:0] PRESET_RESET  = 16'h0000;
  localparam logic [FREQ_W-1:0] FREQ_ZERO     = 16'h0000;
  localparam logic [INDEX_W-1:0] INDEX_ZERO   = 4'h0;

  // keypad edit request into the table
  typedef struct packed {
    logic                 store;
    logic                 direct;
    logic [INDEX_W-1:0]   index;
    logic [FREQ_W-1:0]    value;
  } store_req_t;

  // frequency result
  typedef struct packed {
    logic                 preset_active;
    logic [INDEX_W-1:0]   index;
    logic [FREQ_W-1:0]    freq;
  } freq_out_t;

endpackage : preset_pkg

// ==== verif/term_switches.sv ====
`timescale 1ns/1ps
module term_switches (
  // wanted speed
  input  wire logic [3:0] i_speed,
  // input terminals
  output logic      [5:0] o_terminal
);
  // ---------------
  // switch wiring
  // ---------------
  // scrambled placement
  // spare terminals sit high so a stray count shows
  assign o_terminal = {i_speed[0], 1'b1, i_speed[2], 1'b1, i_speed[3], i_speed[1]};
endmodule : term_switches

// ==== verif/multi_speed_preset_select_checker.sv ====
`timescale 1ns/1ps
module multi_speed_preset_select_checker (
  // clock, reset, controls
  input wire logic                   i_mclk,
  input wire logic                   i_rst,
  input wire logic                   i_run,
  input wire logic [5:0]             i_terminal,
  input wire logic [1:0]             i_freq_source,
  input wire logic [15:0]            i_max_freq,
  input wire logic [15:0]            i_terminal_ref,
  input wire preset_pkg::store_req_t i_edit,
  // outputs
  input wire logic [15:0]            o_output_frequency_monitor,
  input wire logic [15:0]            o_output_frequency_setting,
  input wire logic [3:0]             o_preset_index,
  input wire logic                   o_preset_active,
  input wire logic                   o_store_done,
  input wire logic                   o_store_rejected
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic ok;
  assign ok = (i_edit.value <= i_max_freq) && (i_edit.direct || !i_run);
  sequence s_take; i_edit.store && ok; endsequence
  sequence s_quiet; $stable(i_terminal)[*4]; endsequence
  property p_done; s_take |=> o_store_done && !o_store_rejected; endproperty
  a_done: assert property (p_done) else $error("store taken without done");
  property p_refuse; i_edit.store && !ok |=> o_store_rejected && !o_store_done; endproperty
  a_refuse: assert property (p_refuse) else $error("bad store not refused");
  property p_idle; !i_edit.store |=> !o_store_done && !o_store_rejected; endproperty
  a_idle: assert property (p_idle) else $error("pulse without store");
  property p_active; o_preset_active == (o_preset_index != 4'h0); endproperty
  a_active: assert property (p_active) else $error("active flag wrong");
  property p_stop; !i_run ##1 !i_run |-> o_output_frequency_monitor == 16'h0000; endproperty
  a_stop: assert property (p_stop) else $error("monitor not zero in stop");
  property p_ref;
    (i_run && i_freq_source == 2'h1 && $stable(i_terminal_ref))[*2] ##0 !o_preset_active
      |-> o_output_frequency_monitor == i_terminal_ref;
  endproperty
  a_ref: assert property (p_ref) else $error("terminal reference lost");
  // table written at the take edge, setting register reloads one edge later
  property p_setting;
    s_take ##0 i_edit.direct |-> ##2
      o_preset_index != $past(i_edit.index, 2)
      || o_output_frequency_setting == $past(i_edit.value, 2);
  endproperty
  a_setting: assert property (p_setting) else $error("stored value not shown");
  property p_hold; s_quiet |=> $stable(o_preset_index); endproperty
  a_hold: assert property (p_hold) else $error("index moved alone");
endmodule : multi_speed_preset_select_checker
bind multi_speed_preset_select multi_speed_preset_select_checker u_chk (.*);

// ==== verif/multi_speed_preset_select_tb_top.sv ====
`timescale 1ns/1ps
module multi_speed_preset_select_tb_top;
  logic                   i_mclk = 1'b0;
  logic                   i_rst  = 1'b1;
  logic                   i_run  = 1'b0;
  logic [3:0]             speed  = 4'h0;
  logic [1:0]             src    = 2'h1;
  logic [7:0]             func [6] = '{8'h03, 8'h05, 8'h00, 8'h04, 8'h00, 8'h02};
  preset_pkg::store_req_t edit   = '0;
  logic [5:0]             term;
  logic [15:0]            mon, setv;
  logic [3:0]             idx;
  logic                   act, done, rej;
  int                     error_cnt = 0;
  int                     cmp_count = 0;
  always #10 i_mclk = ~i_mclk;
  term_switches u_sw (.i_speed(speed), .o_terminal(term));
  multi_speed_preset_select DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_terminal(term),
    .i_term_func(func), .i_freq_source(src), .i_max_freq(16'h1000), .i_run(i_run),
    .i_terminal_ref(16'h0ABC), .i_other_ref(16'h0DEF), .i_edit(edit),
    .o_output_frequency_monitor(mon), .o_output_frequency_setting(setv),
    .o_preset_index(idx), .o_preset_active(act), .o_store_done(done), .o_store_rejected(rej));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // terminals need two sync edges plus the output register
  task automatic sel(input logic [3:0] s);
    speed = s;
    repeat (4) @(posedge i_mclk);
    #1;
  endtask : sel
  task automatic store(input logic d, input logic [15:0] v, input logic ok);
    @(posedge i_mclk) #1 edit = {1'b1, d, 4'hF, v};
    @(posedge i_mclk) #1 edit.store = 1'b0;
    chk("done", {15'h0, ok}, {15'h0, done});
    chk("rejected", {15'h0, !ok}, {15'h0, rej});
    // setting register reloads one edge after the table write
    @(posedge i_mclk) #1;
  endtask : store
  task automatic t_fill;
    for (int k = 0; k < 16; k++) begin
      sel(k[3:0]);
      chk("index", {12'h0, k[3:0]}, {12'h0, idx});
      store(1'b0, 16'h0100 + k[15:0], 1'b1);
      chk("setting", 16'h0100 + k[15:0], setv);
    end
    $display("t_fill finished");
  endtask : t_fill
  task automatic t_refuse;
    store(1'b0, 16'h1001, 1'b0);
    edit.value = 16'h0055;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("kept", 16'h010F, setv);
    i_run = 1'b1;
    store(1'b0, 16'h0200, 1'b0);
    store(1'b1, 16'h0777, 1'b1);
    chk("direct", 16'h0777, setv);
    $display("t_refuse finished");
  endtask : t_refuse
  task automatic t_run;
    sel(4'h0);
    chk("ref", 16'h0ABC, mon);
    chk("base", 16'h0100, setv);
    for (int k = 1; k < 16; k++) begin
      sel(k[3:0]);
      chk("monitor", (k == 15) ? 16'h0777 : 16'h0100 + k[15:0], mon);
    end
    $display("t_run finished");
  endtask : t_run
  task automatic t_spare;
    sel(4'h0);
    func[1] = 8'h00;
    sel(4'h9);
    chk("spare", 16'h0101, mon);
    sel(4'h0);
    func[1] = 8'h05;
    src = 2'h2;
    sel(4'h0);
    chk("other", 16'h0DEF, mon);
    sel(4'h3);
    chk("other preset", 16'h0103, mon);
    src = 2'h1;
    sel(4'h0);
    $display("t_spare finished");
  endtask : t_spare
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (5) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    t_fill();
    t_refuse();
    t_run();
    t_spare();
    give_verdict();
  end
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule : multi_speed_preset_select_tb_top
